// >>> vphy_pkg.sv
/*
 * Shared constants and types for the emulated PHY register set.
 * Assumes a single core clock domain and that all users reference
 * these items through the package scope.
 */
package vphy_pkg;

	// Memory map byte offsets of the emulated registers.
	localparam logic [11:0] MM_OFF_CTRL = 12'h1C0;
	localparam logic [11:0] MM_OFF_LAST = 12'h1D8;
	localparam logic [11:0] MM_OFF_SPEC = 12'h1DC;
	localparam logic [11:0] MM_STRIDE   = 12'h004;

	// Serial register indexes.
	localparam logic [4:0] IDX_CTRL = 5'h00;
	localparam logic [4:0] IDX_STAT = 5'h01;
	localparam logic [4:0] IDX_IDH  = 5'h02;
	localparam logic [4:0] IDX_IDL  = 5'h03;
	localparam logic [4:0] IDX_ADV  = 5'h04;
	localparam logic [4:0] IDX_LPA  = 5'h05;
	localparam logic [4:0] IDX_EXP  = 5'h06;
	localparam logic [4:0] IDX_SPEC = 5'h1F;

	// Control register bit positions.
	localparam int CTL_RST_BIT     = 15;
	localparam int CTL_RESTART_BIT = 9;
	localparam int CTL_FIELD_HI    = 14;
	localparam int CTL_FIELD_LO    = 7;

	// Storage of control bits 14 down to 7, in bit order.
	typedef struct packed {
		logic loopback;
		logic speed_100;
		logic an_en;
		logic pdown;
		logic iso;
		logic restart;
		logic full_dup;
		logic coltest;
	} vphy_ctl_t;

	// Reset values.
	localparam vphy_ctl_t   CTRL_DEF     = 8'h20;
	localparam logic [15:0] STAT_VAL     = 16'h782D;
	localparam logic [15:0] ID_DEF       = 16'h0000;
	localparam logic        NEG_SPD_DEF  = 1'b1;
	localparam logic        NEG_DUP_DEF  = 1'b1;

	// Serial management frame layout.
	localparam logic [5:0] PRE_LEN   = 6'h20;
	localparam logic [5:0] HDR_LAST  = 6'h0C;
	localparam logic [5:0] TA_LAST   = 6'h01;
	localparam logic [5:0] DATA_LAST = 6'h0F;
	localparam logic [5:0] SKIP_LAST = 6'h11;
	localparam logic [1:0] ST_CODE   = 2'h1;
	localparam logic [1:0] OP_RD     = 2'h2;
	localparam logic [1:0] OP_WR     = 2'h1;

	typedef enum logic [2:0] {
		MD_PRE,
		MD_HDR,
		MD_TA,
		MD_DATA,
		MD_SKIP
	} vphy_md_st_t;

	// Memory map request.
	typedef struct packed {
		logic        req;
		logic        we;
		logic [11:0] addr;
		logic [31:0] wdata;
	} vphy_mm_req_t;

	// Nibble-wide MAC data stream.
	typedef struct packed {
		logic       en;
		logic [3:0] d;
	} vphy_mii_t;

endpackage

// >>> vphy_edge_det.sv
/*
 * Rising edge finder for the sampled management clock, carrying the
 * data bit seen in the same cycle. Inputs are synchronous to core_clk.
 */
module vphy_edge_det (
	// Clock and reset.
	input  wire logic core_clk,
	input  wire logic rst,
	// Sampled clock and data.
	input  wire logic sig,
	input  wire logic dat,
	// One-cycle edge pulse and the data bit that went with it.
	output logic      rise,
	output logic      dat_q
);

	typedef struct packed {
		logic prev;
		logic rise;
		logic dat;
	} vphy_edge_st_t;

	vphy_edge_st_t s_r;
	vphy_edge_st_t s_nxt;

	// The pulse comes one cycle after the first cycle in which the clock reads high.
	always_comb begin
		s_nxt      = s_r;
		s_nxt.prev = sig;
		s_nxt.rise = sig & ~s_r.prev;
		s_nxt.dat  = dat;
	end

	// State register.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rise  = s_r.rise;
	assign dat_q = s_r.dat;

endmodule

// >>> vphy_rw_field.sv
/*
 * Plain read/write field with a reset value and a synchronous clear.
 * Assumes the writer never asserts write and clear together with
 * different intent; clear wins.
 */
module vphy_rw_field #(
	parameter int          W   = 16,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset.
	input  wire logic         core_clk,
	input  wire logic         rst,
	// Control.
	input  wire logic         clr,
	input  wire logic         we,
	input  wire logic [W-1:0] d,
	// Stored value.
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] val;
	} vphy_fld_st_t;

	vphy_fld_st_t s_r;
	vphy_fld_st_t s_nxt;

	// A clear returns the field to its default before any write.
	always_comb begin
		s_nxt = s_r;
		if (clr) begin
			s_nxt.val = RST;
		end else if (we) begin
			s_nxt.val = d;
		end
	end

	// State register.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_r.val <= RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.val;

endmodule

// >>> vphy_regs.sv
/*
 * Emulated single-port PHY register set with memory map and serial
 * management access, plus the loopback and collision test datapath.
 * Assumes all inputs are synchronous to core_clk and that software
 * follows the usage notes below.
 */
// Operation
// - Memory map and serial path share registers.
// - Serial frames answered only at strap address.
// - Serial registers are sixteen bits wide.
// - Memory words pad bits 31-16 with zero.
// - Index decode 0-6 and 31.
// - Loader rewrites whole control register.
// - Bit 15 resets all registers, self clears.
// - Loopback returns host frames, blocks fabric.
// - Bit 13 forces speed without negotiation.
// - Bit 12 enables negotiation, overrides forced bits.
// - Bits 11,10 plain storage, no effect.
// - Bit 9 refreshes negotiation result, self clears.
// - Bit 8 forces duplex without negotiation.
// - Bit 7 asserts collision while host transmits.
// - Bit 6 always reads zero.
// - Status shows link up, no faults.
module vphy_regs (
	// Clock and reset.
	input  wire logic                core_clk,
	input  wire logic                rst,
	// Memory map access.
	input  wire vphy_pkg::vphy_mm_req_t mm,
	output logic               [31:0] mm_rdata,
	output logic                      mm_ack,
	// Configuration loader.
	input  wire logic                 loader_valid,
	input  wire logic          [15:0] loader_data,
	// Serial management pins and address strap.
	input  wire logic                 mdc,
	input  wire logic                 mdio_in,
	output logic                      mdio_out,
	output logic                      mdio_oe,
	input  wire logic           [4:0] phy_addr_strap,
	// Negotiation result offered by the fabric side.
	input  wire logic                 an_result_100,
	input  wire logic                 an_result_fdx,
	// Host MAC and fabric streams.
	input  wire vphy_pkg::vphy_mii_t  host_tx,
	output vphy_pkg::vphy_mii_t       host_rx,
	output logic                      host_col,
	output vphy_pkg::vphy_mii_t       fab_tx,
	input  wire vphy_pkg::vphy_mii_t  fab_rx,
	// Emulated link mode.
	output logic                      phy_speed_100,
	output logic                      phy_full_duplex
);

	typedef struct packed {
		vphy_pkg::vphy_ctl_t   ctl;
		logic                  neg_spd;
		logic                  neg_dup;
		logic [31:0]           mm_rdata;
		logic                  mm_ack;
		vphy_pkg::vphy_md_st_t st;
		logic [5:0]            cnt;
		logic [15:0]           sh;
		logic                  op_rd;
		logic [4:0]            ridx;
		logic                  mdio_out;
		logic                  mdio_oe;
		vphy_pkg::vphy_mii_t   host_rx;
		logic                  host_col;
		vphy_pkg::vphy_mii_t   fab_tx;
		logic                  spd;
		logic                  dup;
	} vphy_regs_st_t;

	vphy_regs_st_t q;
	vphy_regs_st_t n;

	logic        md_rise;
	logic        md_bit;
	logic [15:0] id_hi;
	logic [15:0] id_lo;
	logic        w_en;
	logic [4:0]  w_idx;
	logic [15:0] w_dat;
	logic        soft_rst;
	logic        md_commit;
	logic [15:0] md_wdat;
	logic        mm_take;
	logic        mm_hit;
	logic [4:0]  mm_idx;
	logic [15:0] hdr;

	// Management clock edge finder.
	vphy_edge_det u_mdc (
		.core_clk (core_clk),
		.rst      (rst),
		.sig      (mdc),
		.dat      (mdio_in),
		.rise     (md_rise),
		.dat_q    (md_bit)
	);

	// Identifier registers, cleared by a soft reset.
	vphy_rw_field #(.W(16), .RST(vphy_pkg::ID_DEF)) u_idh (
		.core_clk (core_clk),
		.rst      (rst),
		.clr      (soft_rst),
		.we       (w_en && w_idx == vphy_pkg::IDX_IDH),
		.d        (w_dat),
		.q        (id_hi)
	);
	vphy_rw_field #(.W(16), .RST(vphy_pkg::ID_DEF)) u_idl (
		.core_clk (core_clk),
		.rst      (rst),
		.clr      (soft_rst),
		.we       (w_en && w_idx == vphy_pkg::IDX_IDL),
		.d        (w_dat),
		.q        (id_lo)
	);

	// Sixteen-bit view of a register; unsupported indexes read zero.
	function automatic logic [15:0] rd16(input logic [4:0] idx);
		logic [15:0] v;
		v = 16'h0000;
		unique case (idx)
			vphy_pkg::IDX_CTRL: v = {1'b0, q.ctl, 7'h00};
			vphy_pkg::IDX_STAT: v = vphy_pkg::STAT_VAL;
			vphy_pkg::IDX_IDH:  v = id_hi;
			vphy_pkg::IDX_IDL:  v = id_lo;
			default:            v = 16'h0000;
		endcase
		return v;
	endfunction

	// Memory map decode: one aligned word per index, plus the special one.
	always_comb begin
		mm_hit = 1'b0;
		mm_idx = 5'h00;
		if (mm.addr == vphy_pkg::MM_OFF_SPEC) begin
			mm_hit = 1'b1;
			mm_idx = vphy_pkg::IDX_SPEC;
		end else if (mm.addr >= vphy_pkg::MM_OFF_CTRL && mm.addr <= vphy_pkg::MM_OFF_LAST
				&& mm.addr[1:0] == 2'h0) begin
			mm_hit = 1'b1;
			mm_idx = 5'((mm.addr - vphy_pkg::MM_OFF_CTRL) >> 2);
		end
	end

	// Write arbitration: loader, then serial commit, then memory map.
	assign hdr       = {q.sh[14:0], md_bit};
	assign md_wdat   = hdr;
	assign md_commit = md_rise && q.st == vphy_pkg::MD_DATA && !q.op_rd
		&& q.cnt == vphy_pkg::DATA_LAST;
	assign mm_take   = mm.req && !q.mm_ack && !loader_valid && !md_commit;
	always_comb begin
		w_en  = 1'b0;
		w_idx = vphy_pkg::IDX_CTRL;
		w_dat = 16'h0000;
		if (loader_valid) begin
			w_en  = 1'b1;
			w_dat = loader_data;
		end else if (md_commit) begin
			w_en  = 1'b1;
			w_idx = q.ridx;
			w_dat = md_wdat;
		end else if (mm_take && mm.we && mm_hit) begin
			w_en  = 1'b1;
			w_idx = mm_idx;
			w_dat = mm.wdata[15:0];
		end
	end
	assign soft_rst = w_en && w_idx == vphy_pkg::IDX_CTRL && w_dat[vphy_pkg::CTL_RST_BIT];

	// Next state of the register file, serial engine and datapath.
	always_comb begin
		n = q;
		n.ctl.restart = 1'b0;
		if (soft_rst) begin
			n.ctl     = vphy_pkg::CTRL_DEF;
			n.neg_spd = vphy_pkg::NEG_SPD_DEF;
			n.neg_dup = vphy_pkg::NEG_DUP_DEF;
		end else if (w_en && w_idx == vphy_pkg::IDX_CTRL) begin
			n.ctl = w_dat[vphy_pkg::CTL_FIELD_HI:vphy_pkg::CTL_FIELD_LO];
			if (w_dat[vphy_pkg::CTL_RESTART_BIT]) begin
				n.neg_spd = an_result_100;
				n.neg_dup = an_result_fdx;
			end
		end
		// Memory map answer, one cycle after the request is taken.
		n.mm_ack = mm_take;
		if (mm_take) begin
			n.mm_rdata = mm_hit ? {16'h0000, rd16(mm_idx)} : 32'h0000_0000;
		end
		// Serial frame engine, advanced on each management clock rise.
		if (md_rise) begin
			unique case (q.st)
				vphy_pkg::MD_PRE: begin
					if (md_bit) begin
						n.cnt = (q.cnt == vphy_pkg::PRE_LEN) ? q.cnt : q.cnt + 6'h01;
					end else if (q.cnt == vphy_pkg::PRE_LEN) begin
						n.st  = vphy_pkg::MD_HDR;
						n.cnt = 6'h00;
						n.sh  = 16'h0000;
					end else begin
						n.cnt = 6'h00;
					end
				end
				vphy_pkg::MD_HDR: begin
					n.sh  = hdr;
					n.cnt = q.cnt + 6'h01;
					if (q.cnt == vphy_pkg::HDR_LAST) begin
						n.cnt   = 6'h00;
						n.ridx  = hdr[4:0];
						n.op_rd = hdr[11:10] == vphy_pkg::OP_RD;
						if (hdr[13:12] == vphy_pkg::ST_CODE && hdr[9:5] == phy_addr_strap
								&& (hdr[11:10] == vphy_pkg::OP_RD
								|| hdr[11:10] == vphy_pkg::OP_WR)) begin
							n.st = vphy_pkg::MD_TA;
						end else begin
							n.st = vphy_pkg::MD_SKIP;
						end
					end
				end
				vphy_pkg::MD_TA: begin
					n.cnt = q.cnt + 6'h01;
					if (q.cnt != vphy_pkg::TA_LAST) begin
						n.mdio_oe  = q.op_rd;
						n.mdio_out = 1'b0;
					end else begin
						n.st  = vphy_pkg::MD_DATA;
						n.cnt = 6'h00;
						if (q.op_rd) begin
							{n.mdio_out, n.sh} = {rd16(q.ridx), 1'b0};
						end
					end
				end
				vphy_pkg::MD_DATA: begin
					n.cnt = q.cnt + 6'h01;
					if (q.op_rd) begin
						n.mdio_out = q.sh[15];
						n.sh       = {q.sh[14:0], 1'b0};
					end else begin
						n.sh = hdr;
					end
					if (q.cnt == vphy_pkg::DATA_LAST) begin
						n.st       = vphy_pkg::MD_PRE;
						n.cnt      = 6'h00;
						n.mdio_oe  = 1'b0;
						n.mdio_out = 1'b0;
					end
				end
				vphy_pkg::MD_SKIP: begin
					n.cnt = q.cnt + 6'h01;
					if (q.cnt == vphy_pkg::SKIP_LAST) begin
						n.st  = vphy_pkg::MD_PRE;
						n.cnt = 6'h00;
					end
				end
			endcase
		end
		// Loopback steering and collision test.
		n.fab_tx   = q.ctl.loopback ? '0 : host_tx;
		n.host_rx  = q.ctl.loopback ? host_tx : fab_rx;
		n.host_col = q.ctl.coltest && host_tx.en;
		// Effective link mode.
		n.spd = q.ctl.an_en ? q.neg_spd : q.ctl.speed_100;
		n.dup = q.ctl.an_en ? q.neg_dup : q.ctl.full_dup;
	end

	// State register.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q          <= '0;
			q.ctl      <= vphy_pkg::CTRL_DEF;
			q.neg_spd  <= vphy_pkg::NEG_SPD_DEF;
			q.neg_dup  <= vphy_pkg::NEG_DUP_DEF;
			q.st       <= vphy_pkg::MD_PRE;
		end else begin
			q <= n;
		end
	end

	assign mm_rdata        = q.mm_rdata;
	assign mm_ack          = q.mm_ack;
	assign mdio_out        = q.mdio_out;
	assign mdio_oe         = q.mdio_oe;
	assign host_rx         = q.host_rx;
	assign host_col        = q.host_col;
	assign fab_tx          = q.fab_tx;
	assign phy_speed_100   = q.spd;
	assign phy_full_duplex = q.dup;

	// Checks.
	sequence s_soft_rst;
		soft_rst;
	endsequence
	sequence s_bad_addr;
		md_rise && q.st == vphy_pkg::MD_HDR && q.cnt == vphy_pkg::HDR_LAST
			&& hdr[9:5] != phy_addr_strap;
	endsequence

	a_loop_return: assert property (@(posedge core_clk) disable iff (rst)
		q.ctl.loopback && host_tx.en |=> host_rx.en && !fab_tx.en)
		else $error("Loopback frame not returned to host.");
	a_col_test: assert property (@(posedge core_clk) disable iff (rst)
		q.ctl.coltest && host_tx.en |=> host_col)
		else $error("Collision test did not assert collision.");
	a_col_quiet: assert property (@(posedge core_clk) disable iff (rst)
		!host_tx.en |=> !host_col)
		else $error("Collision without host transmit.");
	a_soft_reset: assert property (@(posedge core_clk) disable iff (rst)
		s_soft_rst |=> q.ctl == vphy_pkg::CTRL_DEF && id_hi == vphy_pkg::ID_DEF
			&& id_lo == vphy_pkg::ID_DEF)
		else $error("Soft reset did not restore defaults.");
	a_restart_sc: assert property (@(posedge core_clk) disable iff (rst)
		q.ctl.restart |=> !q.ctl.restart)
		else $error("Restart bit did not clear itself.");
	a_forced_speed: assert property (@(posedge core_clk) disable iff (rst)
		!q.ctl.an_en |=> phy_speed_100 == $past(q.ctl.speed_100))
		else $error("Forced speed not applied.");
	a_forced_duplex: assert property (@(posedge core_clk) disable iff (rst)
		!q.ctl.an_en |=> phy_full_duplex == $past(q.ctl.full_dup))
		else $error("Forced duplex not applied.");
	a_an_override: assert property (@(posedge core_clk) disable iff (rst)
		q.ctl.an_en |=> phy_speed_100 == $past(q.neg_spd))
		else $error("Negotiated speed not used.");
	a_mm_padding: assert property (@(posedge core_clk) disable iff (rst)
		mm_ack |-> mm_rdata[31:16] == 16'h0000 && ($past(mm_idx) != vphy_pkg::IDX_CTRL
		|| (!mm_rdata[15] && mm_rdata[6:0] == 7'h00)))
		else $error("Padding bits read nonzero.");
	a_strap_ignore: assert property (@(posedge core_clk) disable iff (rst)
		s_bad_addr |=> !mdio_oe [*8])
		else $error("Drove management data for foreign address.");
	a_loader_write: assert property (@(posedge core_clk) disable iff (rst)
		loader_valid && !loader_data[vphy_pkg::CTL_RST_BIT]
		|=> q.ctl[7:3] == $past(loader_data[14:10]))
		else $error("Loader did not rewrite control register.");

endmodule

// >>> vphy_mdio_host.sv
/*
 * Host MAC side of the serial management link: builds read and write
 * frames on mdc and the shared data line.
 * Assumes the device samples data on mdc rising edges and that the
 * data line carries a pull-up.
 */
module vphy_mdio_host (
	// Core clock that paces the management clock.
	input  wire logic core_clk,
	// Management pins.
	output logic      mdc,
	output logic      mdio_in,
	input  wire logic mdio_out,
	input  wire logic mdio_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	logic h_oe;
	logic h_bit;

	// Line level: the host when it drives, then the device, else the pull-up.
	assign mdio_in = h_oe ? h_bit : (mdio_oe ? mdio_out : 1'b1);

	// The management clock stands low between frames.
	initial begin
		mdc = 1'b0;
		h_oe = 1'b0;
		h_bit = 1'b1;
	end

	// One mdc period; the line is sampled just before the rise.
	task automatic bit_cyc(input logic oe, input logic b, output logic s);
		@(posedge core_clk);
		#1;
		mdc = 1'b0;
		h_oe = oe;
		h_bit = b;
		repeat (4) @(posedge core_clk);
		#1;
		s = mdio_in;
		mdc = 1'b1;
		repeat (3) @(posedge core_clk);
	endtask

	// Whole frame; on reads the host releases the line from turnaround on.
	task automatic frame(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
			input logic [15:0] wd, output logic [15:0] rd);
		logic [13:0] hdr;
		logic [17:0] tail;
		logic        s;
		hdr = {2'b01, (wr ? 2'b01 : 2'b10), pa, ra};
		tail = {2'b10, wd};
		rd = 16'h0000;
		for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
		for (int i = 17; i >= 0; i--) begin
			bit_cyc(wr, tail[i], s);
			if (i < 16) rd[i] = s;
		end
		@(posedge core_clk);
		#1;
		mdc = 1'b0;
		h_oe = 1'b0;
	endtask
endmodule

// >>> testbench.sv
/*
 * Self-checking bench for the emulated PHY register set: memory map,
 * loader, serial management through the host model, and the streams.
 * Assumes the package and design files are compiled first.
 */
module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	logic                   core_clk, rst, mm_ack, loader_valid, mdc, mdio_in;
	logic                   mdio_out, mdio_oe, an_result_100, an_result_fdx;
	logic                   host_col, phy_speed_100, phy_full_duplex;
	logic            [31:0] mm_rdata, rw;
	logic            [15:0] loader_data, rdv;
	logic             [4:0] phy_addr_strap;
	vphy_pkg::vphy_mm_req_t mm;
	vphy_pkg::vphy_mii_t    host_tx, host_rx, fab_tx, fab_rx;
	int                     error_cnt, n_checks;
	logic            [11:0] offs [4] = '{12'h1D0, 12'h1D4, 12'h1D8, 12'h1DC};
	logic             [4:0] idxs [4] = '{5'h04, 5'h05, 5'h06, 5'h1F};

	// Device under test and the host-side management model.
	vphy_regs DUT (.core_clk(core_clk), .rst(rst), .mm(mm), .mm_rdata(mm_rdata),
		.mm_ack(mm_ack), .loader_valid(loader_valid), .loader_data(loader_data),
		.mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.phy_addr_strap(phy_addr_strap), .an_result_100(an_result_100),
		.an_result_fdx(an_result_fdx), .host_tx(host_tx), .host_rx(host_rx),
		.host_col(host_col), .fab_tx(fab_tx), .fab_rx(fab_rx),
		.phy_speed_100(phy_speed_100), .phy_full_duplex(phy_full_duplex));
	vphy_mdio_host host (.core_clk(core_clk), .mdc(mdc), .mdio_in(mdio_in),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe));

	// Prints the verdict and ends the run.
	task automatic finish_test;
		if (error_cnt == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Compares a register word.
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Compares a pin or stream value.
	task automatic chk_sig(input logic [4:0] got, input logic [4:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Memory map cycle: request held until the acknowledge edge has passed.
	task automatic mm_xfer(input logic we, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		int n;
		@(posedge core_clk);
		#1;
		mm = {1'b1, we, a, wd};
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (mm_ack !== 1'b1 && n < 50);
		rd = mm_rdata;
		chk_sig({4'h0, mm_ack}, 5'h01);
		@(posedge core_clk);
		#1;
		mm.req = 1'b0;
	endtask

	// Shorthands for memory map and serial accesses.
	task automatic mm_wr(input logic [11:0] a, input logic [31:0] d);
		mm_xfer(1'b1, a, d, rw);
	endtask
	task automatic mm_chk(input logic [11:0] a, input logic [31:0] exp);
		mm_xfer(1'b0, a, 32'h0000_0000, rw);
		chk_reg(rw, exp);
	endtask
	task automatic sr_chk(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp);
		host.frame(1'b0, pa, ra, 16'h0000, rdv);
		chk_reg({16'h0000, rdv}, {16'h0000, exp});
	endtask
	task automatic sw(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
		host.frame(1'b1, pa, ra, d, rdv);
	endtask

	// Link mode check, a few cycles after the control change.
	task automatic mode_chk(input logic [1:0] exp);
		repeat (3) @(posedge core_clk);
		#1;
		chk_sig({3'h0, phy_speed_100, phy_full_duplex}, {3'h0, exp});
	endtask

	// Drives one host nibble and checks both stream outputs and collision.
	task automatic strm(input logic [4:0] tx, input logic [4:0] rx, input logic [4:0] fab,
			input logic col);
		@(posedge core_clk);
		#1;
		host_tx = tx;
		repeat (2) @(posedge core_clk);
		#1;
		chk_sig(host_rx, rx);
		chk_sig(fab_tx, fab);
		chk_sig({4'h0, host_col}, {4'h0, col});
	endtask

	// Clock at 200 MHz.
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Cuts a hang short well after the tests should have ended.
	initial begin
		repeat (40000) @(posedge core_clk);
		error_cnt++;
		finish_test();
	end

	// Main sequence.
	initial begin
		error_cnt = 0;
		n_checks = 0;
		mm = '0;
		loader_valid = 1'b0;
		loader_data = 16'h0000;
		phy_addr_strap = 5'h0B;
		an_result_100 = 1'b0;
		an_result_fdx = 1'b1;
		host_tx = '0;
		fab_rx = 5'h15;
		rst = 1'b1;
		repeat (12) @(posedge core_clk);
		#1;
		rst = 1'b0;
		mm_chk(12'h1C0, 32'h0000_1000);
		mm_chk(12'h1C4, 32'h0000_782D);
		mode_chk(2'h3);
		mm_wr(12'h1C0, 32'hFFFF_7FFF);
		mm_chk(12'h1C0, 32'h0000_7D80);
		mode_chk(2'h1);
		strm(5'h1A, 5'h1A, 5'h00, 1'b1);
		strm(5'h0A, 5'h0A, 5'h00, 1'b0);
		mm_wr(12'h1C0, 32'h0000_2100);
		mode_chk(2'h3);
		strm(5'h1A, 5'h15, 5'h1A, 1'b0);
		mm_wr(12'h1C0, 32'h0000_0000);
		mode_chk(2'h0);
		mm_wr(12'h1C0, 32'h0000_3100);
		mode_chk(2'h1);
		sr_chk(5'h0B, 5'h00, 16'h3100);
		sr_chk(5'h0B, 5'h01, 16'h782D);
		sw(5'h0B, 5'h02, 16'hA5C3);
		mm_chk(12'h1C8, 32'h0000_A5C3);
		mm_wr(12'h1CC, 32'hFFFF_1234);
		sr_chk(5'h0B, 5'h03, 16'h1234);
		mm_chk(12'h1CC, 32'h0000_1234);
		for (int k = 0; k < 4; k++) begin
			mm_wr(offs[k], 32'hFFFF_FFFF);
			mm_chk(offs[k], 32'h0000_0000);
			sr_chk(5'h0B, idxs[k], 16'h0000);
		end
		mm_wr(12'h1E0, 32'hFFFF_FFFF);
		mm_chk(12'h1E0, 32'h0000_0000);
		sr_chk(5'h0C, 5'h02, 16'hFFFF);
		sw(5'h0C, 5'h02, 16'h1111);
		mm_chk(12'h1C8, 32'h0000_A5C3);
		@(posedge core_clk);
		#1;
		loader_valid = 1'b1;
		loader_data = 16'h4000;
		@(posedge core_clk);
		#1;
		loader_valid = 1'b0;
		mm_chk(12'h1C0, 32'h0000_4000);
		mm_wr(12'h1C0, 32'h0000_8000);
		mm_chk(12'h1C0, 32'h0000_1000);
		mm_chk(12'h1C8, 32'h0000_0000);
		mm_chk(12'h1CC, 32'h0000_0000);
		mode_chk(2'h3);
		finish_test();
	end
endmodule
